/* File: cdcu_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cdcu_cfg.svh"
module cdcu_top
	import cdcu_pkg::*;
#(
	parameter logic [4:0] ABORT_MODE_CODE = 5'h17
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic cp_req,
	input wire logic [3:0] cp_num,
	input wire cdcu_op_t cp_op,
	input wire logic [2:0] cp_op1,
	input wire logic [3:0] cp_crn,
	input wire logic [3:0] cp_crm,
	input wire logic [2:0] cp_op2,
	input wire logic cp_priv,
	input wire logic [31:0] cp_wdata,
	input wire logic [31:0] ext_rdata,
	output logic cp_done,
	output logic cp_undef,
	output logic [31:0] cp_rdata,
	output cdcu_rsel_t ext_sel,
	output logic ext_wr,
	input wire logic jtag_tck,
	input wire logic jtag_tdi,
	input wire logic jtag_sel,
	input wire logic jtag_trst_n,
	output logic jtag_tdo,
	output logic jtag_tdo_oe,
	input wire logic evt_ibrk,
	input wire logic evt_dbrk,
	input wire logic evt_bkpt,
	input wire logic evt_ext,
	input wire logic evt_tbfull,
	input wire logic [6:0] vec_hit,
	input wire logic data_abort_in,
	output logic dbg_take,
	output cdcu_vec_t dbg_vec,
	output logic [4:0] dbg_mode,
	output logic bkpt_loop,
	output logic trace_run,
	output logic halt_mode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// register state
	logic gden_r;
	logic halt_r;
	logic [6:0] trap_r; // index 0 reset, 1 undef, 2 swi, 3 pabt, 4 dabt, 5 irq, 6 fiq
	logic sticky_r;
	logic [2:0] entry_r;
	logic tbmode_r;
	logic tben_r;
	logic [31:0] view;
	logic [3:0] sy1_r;
	logic [3:0] sy2_r;
	logic [3:0] sy3_r;
	logic [3:0] lvl_r;
	logic tck_prev_r;
	logic tck_rise;
	logic trst_act;
	cdcu_jst_t jst_r;
	cdcu_jst_t jst_nxt;
	logic [31:0] shreg_r;
	logic is_sys;
	logic is_dbg;
	logic bad_req;
	logic acc_ok;
	logic sw_wr;
	cdcu_rsel_t rsel;
	logic [6:0] vt_eff;
	logic vt_any;
	logic take_nxt;
	logic [2:0] entry_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// control/status view; reserved bits read back as zero
	always_comb begin
		view = 32'h0;
		view[`CDCU_GDEN_BIT] = gden_r;
		view[`CDCU_HALT_BIT] = halt_r;
		view[`CDCU_TRAP_FIQ_BIT] = trap_r[6];
		view[`CDCU_TRAP_IRQ_BIT] = trap_r[5];
		view[`CDCU_TRAP_DAB_BIT] = trap_r[4];
		view[`CDCU_TRAP_PAB_BIT] = trap_r[3];
		view[`CDCU_TRAP_SWI_BIT] = trap_r[2];
		view[`CDCU_TRAP_UND_BIT] = trap_r[1];
		view[`CDCU_TRAP_RST_BIT] = trap_r[0];
		view[`CDCU_STICKY_BIT] = sticky_r;
		view[`CDCU_ENTRY_HI:`CDCU_ENTRY_LO] = entry_r;
		view[`CDCU_TBMODE_BIT] = tbmode_r;
		view[`CDCU_TBEN_BIT] = tben_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// test port pins: three stages, a level counts once stages two and three agree
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sy1_r <= `CDCU_SYNC_RST;
			sy2_r <= `CDCU_SYNC_RST;
			sy3_r <= `CDCU_SYNC_RST;
			lvl_r <= `CDCU_SYNC_RST;
			tck_prev_r <= 1'b0;
		end else if (clk_en) begin
			sy1_r <= {jtag_trst_n, jtag_sel, jtag_tdi, jtag_tck};
			sy2_r <= sy1_r;
			sy3_r <= sy2_r;
			lvl_r <= (lvl_r & (sy2_r ^ sy3_r)) | (sy3_r & ~(sy2_r ^ sy3_r));
			tck_prev_r <= lvl_r[0];
		end
	end

	// tck runs far slower than mclk, so each filtered rising edge is seen exactly once
	assign tck_rise = lvl_r[0] & ~tck_prev_r;
	assign trst_act = ~lvl_r[3];

	////////////////////////////////////////////////////////////////////////////////
	// scan sequencer: capture on select, shift on tck, update on release
	always_comb begin
		case (jst_r)
			JS_IDLE: jst_nxt = lvl_r[2] ? JS_SHIFT : JS_IDLE;
			JS_SHIFT: jst_nxt = lvl_r[2] ? JS_SHIFT : JS_UPD;
			JS_UPD: jst_nxt = JS_IDLE;
			default: jst_nxt = JS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || trst_act) begin
			jst_r <= JS_IDLE;
		end else if (clk_en) begin
			jst_r <= jst_nxt;
		end
	end

	// shift register: loaded with the live view so the debugger reads every bit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shreg_r <= 32'h0;
		end else if (clk_en) begin
			if (jst_r == JS_IDLE && jst_nxt == JS_SHIFT) begin
				shreg_r <= view;
			end else if (jst_r == JS_SHIFT && tck_rise) begin
				shreg_r <= {lvl_r[1], shreg_r[31:1]};
			end
		end
	end

	// serial out from a flop; driven only while the scan is selected
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			jtag_tdo <= 1'b0;
			jtag_tdo_oe <= 1'b0;
		end else if (clk_en) begin
			jtag_tdo <= shreg_r[0];
			jtag_tdo_oe <= (jst_r == JS_SHIFT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// coprocessor decode; opcode fields play no part in the selection
	assign is_sys = cp_req && cp_num == `CDCU_CP_SYS;
	assign is_dbg = cp_req && cp_num == `CDCU_CP_DBG;
	// data-operations and user mode both trap; load/store only reach the debug bank
	assign bad_req = (is_sys || is_dbg) && (!cp_priv || cp_op == CPOP_DATA
		|| (is_sys && (cp_op == CPOP_LOAD || cp_op == CPOP_STORE)));
	assign acc_ok = (is_sys || is_dbg) && !bad_req;

	always_comb begin
		rsel = RS_NONE;
		if (is_sys && cp_crn == `CDCU_SYS_CRN) begin
			case (cp_crm)
				`CDCU_CRM_IBRK0: rsel = RS_IBRK0;
				`CDCU_CRM_IBRK1: rsel = RS_IBRK1;
				`CDCU_CRM_DBRK0: rsel = RS_DBRK0;
				`CDCU_CRM_DBRK1: rsel = RS_DBRK1;
				`CDCU_CRM_DBCTL: rsel = RS_DBCTL;
				default: rsel = RS_NONE;
			endcase
		end else if (is_dbg) begin
			case (cp_crn)
				`CDCU_CRN_XMIT: rsel = RS_XMIT;
				`CDCU_CRN_RECV: rsel = RS_RECV;
				`CDCU_CRN_CTLSTAT: rsel = RS_CTLSTAT;
				`CDCU_CRN_TRACE: rsel = RS_TRACE;
				`CDCU_CRN_CHK0: rsel = RS_CHK0;
				`CDCU_CRN_CHK1: rsel = RS_CHK1;
				`CDCU_CRN_XFER: rsel = RS_XFER;
				default: rsel = RS_NONE;
			endcase
		end
	end

	assign sw_wr = acc_ok && rsel == RS_CTLSTAT && (cp_op == CPOP_WRITE || cp_op == CPOP_LOAD);

	// answer one cycle after the request; unknown numbers read zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cp_done <= 1'b0;
			cp_undef <= 1'b0;
			cp_rdata <= 32'h0;
			ext_sel <= RS_NONE;
			ext_wr <= 1'b0;
		end else if (clk_en) begin
			cp_done <= acc_ok;
			cp_undef <= bad_req;
			ext_sel <= acc_ok ? rsel : RS_NONE;
			ext_wr <= acc_ok && rsel != RS_CTLSTAT && rsel != RS_NONE
				&& (cp_op == CPOP_WRITE || cp_op == CPOP_LOAD);
			if (!acc_ok || rsel == RS_NONE) begin
				cp_rdata <= 32'h0;
			end else if (rsel == RS_CTLSTAT) begin
				cp_rdata <= view;
			end else begin
				cp_rdata <= ext_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event arbitration; the reset trap ignores the global enable
	assign vt_eff = vec_hit & trap_r & (gden_r ? 7'h7F : 7'h01);
	assign vt_any = |vt_eff;

	always_comb begin
		take_nxt = 1'b1;
		entry_nxt = entry_r;
		if (vt_any) begin
			entry_nxt = `CDCU_ENT_VTRAP;
		end else if (gden_r && evt_dbrk) begin
			entry_nxt = `CDCU_ENT_DBRK;
		end else if (gden_r && evt_ext) begin
			entry_nxt = `CDCU_ENT_EXT;
		end else if (gden_r && evt_tbfull) begin
			entry_nxt = `CDCU_ENT_TBFULL;
		end else if (gden_r && evt_ibrk) begin
			entry_nxt = `CDCU_ENT_IBRK;
		end else if (gden_r && evt_bkpt) begin
			entry_nxt = `CDCU_ENT_BKPT;
		end else begin
			take_nxt = 1'b0;
		end
	end

	// entry outputs: halt uses the reset vector, monitor picks an abort vector
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dbg_take <= 1'b0;
			dbg_vec <= VEC_RESET;
			dbg_mode <= `CDCU_DEBUG_MODE;
		end else if (clk_en) begin
			dbg_take <= take_nxt;
			if (take_nxt) begin
				if (halt_r) begin
					dbg_vec <= VEC_RESET;
					dbg_mode <= `CDCU_DEBUG_MODE;
				end else begin
					dbg_vec <= (entry_nxt == `CDCU_ENT_DBRK) ? VEC_DABT : VEC_PABT;
					dbg_mode <= ABORT_MODE_CODE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software-owned bits: cleared by processor reset, test reset leaves them
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gden_r <= 1'b0;
			tbmode_r <= 1'b0;
			entry_r <= `CDCU_ENT_RESET;
		end else if (clk_en) begin
			if (sw_wr) begin
				gden_r <= cp_wdata[`CDCU_GDEN_BIT];
				tbmode_r <= cp_wdata[`CDCU_TBMODE_BIT];
			end
			// a debug entry overrides a software write in the same cycle
			if (take_nxt) begin
				entry_r <= entry_nxt;
			end else if (sw_wr) begin
				entry_r <= cp_wdata[`CDCU_ENTRY_HI:`CDCU_ENTRY_LO];
			end
		end
	end

	// trace enable: hardware clear on entry wins over a software set
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tben_r <= 1'b0;
		end else if (clk_en) begin
			if (take_nxt) begin
				tben_r <= 1'b0;
			end else if (sw_wr) begin
				tben_r <= cp_wdata[`CDCU_TBEN_BIT];
			end
		end
	end

	// sticky abort: an abort in halt mode sets it even against a software clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sticky_r <= 1'b0;
		end else if (clk_en) begin
			if (data_abort_in && halt_r) begin
				sticky_r <= 1'b1;
			end else if (sw_wr) begin
				sticky_r <= cp_wdata[`CDCU_STICKY_BIT];
			end
		end
	end

	// test-port-owned bits: only test reset clears them, so a trap survives
	// a processor reset and can catch the reset vector
	always_ff @(posedge mclk) begin
		if (clk_en) begin
			if (trst_act) begin
				halt_r <= 1'b0;
				trap_r <= 7'h0;
			end else if (jst_r == JS_UPD) begin
				halt_r <= shreg_r[`CDCU_HALT_BIT];
				trap_r <= {shreg_r[`CDCU_TRAP_FIQ_BIT], shreg_r[`CDCU_TRAP_IRQ_BIT],
					shreg_r[`CDCU_TRAP_DAB_BIT], shreg_r[`CDCU_TRAP_PAB_BIT],
					shreg_r[`CDCU_TRAP_SWI_BIT], shreg_r[`CDCU_TRAP_UND_BIT],
					shreg_r[`CDCU_TRAP_RST_BIT]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status to the core
	assign bkpt_loop = ~gden_r;
	assign trace_run = tben_r & gden_r;
	assign halt_mode = halt_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_sys_decode;
		clk_en && cp_req && cp_priv && cp_num == `CDCU_CP_SYS && cp_crn == `CDCU_SYS_CRN
			&& cp_crm == `CDCU_CRM_IBRK1 && cp_op == CPOP_WRITE |=> ext_sel == RS_IBRK1 && ext_wr;
	endproperty
	a_sys_decode: assert property (p_sys_decode) else $error("breakpoint decode wrong");

	property p_dbg_read;
		clk_en && cp_req && cp_priv && cp_num == `CDCU_CP_DBG && cp_crn == `CDCU_CRN_CTLSTAT
			&& (cp_op == CPOP_READ || cp_op == CPOP_STORE) |=> cp_done && cp_rdata == $past(view);
	endproperty
	a_dbg_read: assert property (p_dbg_read) else $error("status read wrong");

	property p_dataop;
		clk_en && cp_req && cp_num == `CDCU_CP_DBG && cp_op == CPOP_DATA |=> cp_undef && !cp_done;
	endproperty
	a_dataop: assert property (p_dataop) else $error("data-op not trapped");

	property p_user;
		clk_en && (is_sys || is_dbg) && !cp_priv |=> cp_undef ##1 !cp_undef || $past(bad_req);
	endproperty
	a_user: assert property (p_user) else $error("user access not trapped");

	property p_halt_entry;
		clk_en && take_nxt && halt_r |=> dbg_take && dbg_vec == VEC_RESET
			&& dbg_mode == `CDCU_DEBUG_MODE && !tben_r;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");

	property p_mon_entry;
		clk_en && take_nxt && !halt_r && !vt_any && gden_r && evt_dbrk
			|=> dbg_vec == VEC_DABT && entry_r == `CDCU_ENT_DBRK;
	endproperty
	a_mon_entry: assert property (p_mon_entry) else $error("monitor vector wrong");

	property p_gate;
		clk_en && !gden_r && !(vec_hit[0] && trap_r[0]) |=> !dbg_take;
	endproperty
	a_gate: assert property (p_gate) else $error("event taken while disabled");

	property p_prio;
		clk_en && vt_any && gden_r && evt_dbrk && evt_ibrk |=> entry_r == `CDCU_ENT_VTRAP;
	endproperty
	a_prio: assert property (p_prio) else $error("entry priority wrong");

	property p_proc_reset;
		disable iff (1'b0) !rst_n |=> !gden_r && !tben_r && !sticky_r && entry_r == `CDCU_ENT_RESET;
	endproperty
	a_proc_reset: assert property (p_proc_reset) else $error("processor reset values wrong");

	property p_trst;
		clk_en && trst_act |=> !halt_r && trap_r == 7'h0;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset values wrong");

	property p_port_ro;
		clk_en && !sw_wr && !take_nxt && jst_r == JS_UPD |=> gden_r == $past(gden_r)
			&& tbmode_r == $past(tbmode_r) && entry_r == $past(entry_r);
	endproperty
	a_port_ro: assert property (p_port_ro) else $error("test port wrote software bit");

	property p_sticky;
		clk_en && data_abort_in && halt_r |=> sticky_r [*1] ##0 view[`CDCU_STICKY_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky abort not set");

endmodule : cdcu_top
`default_nettype wire

/* File: cdcu_cfg.svh */
`ifndef CDCU_CFG_SVH
`define CDCU_CFG_SVH
// coprocessor numbers
`define CDCU_CP_SYS 4'hF
`define CDCU_CP_DBG 4'hE
// system coprocessor breakpoint bank: primary number and secondary selectors
`define CDCU_SYS_CRN 4'hE
`define CDCU_CRM_IBRK0 4'h8
`define CDCU_CRM_IBRK1 4'h9
`define CDCU_CRM_DBRK0 4'h0
`define CDCU_CRM_DBRK1 4'h3
`define CDCU_CRM_DBCTL 4'h4
// debug coprocessor primary numbers, secondary always zero
`define CDCU_DBG_CRM 4'h0
`define CDCU_CRN_XMIT 4'h8
`define CDCU_CRN_RECV 4'h9
`define CDCU_CRN_CTLSTAT 4'hA
`define CDCU_CRN_TRACE 4'hB
`define CDCU_CRN_CHK0 4'hC
`define CDCU_CRN_CHK1 4'hD
`define CDCU_CRN_XFER 4'hE
// control/status field positions
`define CDCU_GDEN_BIT 31
`define CDCU_HALT_BIT 30
`define CDCU_TRAP_FIQ_BIT 23
`define CDCU_TRAP_IRQ_BIT 22
`define CDCU_TRAP_DAB_BIT 20
`define CDCU_TRAP_PAB_BIT 19
`define CDCU_TRAP_SWI_BIT 18
`define CDCU_TRAP_UND_BIT 17
`define CDCU_TRAP_RST_BIT 16
`define CDCU_STICKY_BIT 5
`define CDCU_ENTRY_HI 4
`define CDCU_ENTRY_LO 2
`define CDCU_TBMODE_BIT 1
`define CDCU_TBEN_BIT 0
// method-of-entry codes
`define CDCU_ENT_RESET 3'h0
`define CDCU_ENT_IBRK 3'h1
`define CDCU_ENT_DBRK 3'h2
`define CDCU_ENT_BKPT 3'h3
`define CDCU_ENT_EXT 3'h4
`define CDCU_ENT_VTRAP 3'h5
`define CDCU_ENT_TBFULL 3'h6
// processor mode code for the dedicated debug mode
`define CDCU_DEBUG_MODE 5'h15
// synchroniser reset value: tck, tdi, select low, test reset released
`define CDCU_SYNC_RST 4'h8
`endif

/* File: cdcu_pkg.sv */
package cdcu_pkg;
	typedef enum logic [2:0] {
		CPOP_READ = 3'h0,
		CPOP_WRITE = 3'h1,
		CPOP_LOAD = 3'h2,
		CPOP_STORE = 3'h3,
		CPOP_DATA = 3'h4
	} cdcu_op_t;
	typedef enum logic [3:0] {
		RS_NONE = 4'h0,
		RS_IBRK0 = 4'h1,
		RS_IBRK1 = 4'h2,
		RS_DBRK0 = 4'h3,
		RS_DBRK1 = 4'h4,
		RS_DBCTL = 4'h5,
		RS_XMIT = 4'h6,
		RS_RECV = 4'h7,
		RS_CTLSTAT = 4'h8,
		RS_TRACE = 4'h9,
		RS_CHK0 = 4'hA,
		RS_CHK1 = 4'hB,
		RS_XFER = 4'hC
	} cdcu_rsel_t;
	typedef enum logic [1:0] {
		VEC_RESET = 2'h0,
		VEC_PABT = 2'h1,
		VEC_DABT = 2'h2
	} cdcu_vec_t;
	typedef enum logic [2:0] {
		JS_IDLE = 3'b001,
		JS_SHIFT = 3'b010,
		JS_UPD = 3'b100
	} cdcu_jst_t;
endpackage : cdcu_pkg

/* File: cdcu_jtag_host.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// debugger host on the test port; tck rests low between scans
module cdcu_jtag_host (
	output logic jtag_tck,
	output logic jtag_tdi,
	output logic jtag_sel,
	output logic jtag_trst_n,
	input wire logic jtag_tdo,
	input wire logic jtag_tdo_oe
);
	// idle pins at time zero
	initial begin
		jtag_tck = 1'b0;
		jtag_tdi = 1'b0;
		jtag_sel = 1'b0;
		jtag_trst_n = 1'b1;
	end
	// test reset, held well past the pin filter
	task automatic test_reset();
		jtag_trst_n = 1'b0;
		#60;
		jtag_trst_n = 1'b1;
		#40;
	endtask : test_reset
	// one 32-bit scan, lsb first both ways; tdo only counts while driven
	task automatic scan(input logic [31:0] din, output logic [31:0] dout);
		jtag_sel = 1'b1;
		#100;
		for (int i = 0; i < 32; i++) begin
			jtag_tdi = din[i];
			#80;
			dout[i] = jtag_tdo_oe ? jtag_tdo : 1'bx;
			jtag_tck = 1'b1;
			#80;
			jtag_tck = 1'b0;
		end
		#80;
		jtag_sel = 1'b0;
		jtag_tdi = ~jtag_tdi; // a released line must not show a stale bit
		#100;
	endtask : scan
endmodule : cdcu_jtag_host
`default_nettype wire

/* File: cdcu_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cdcu_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module core_debug_control_unit_tb_top import cdcu_pkg::*;;
	localparam logic [4:0] ABT = 5'h17;
	localparam logic [6:0] HLT = {VEC_RESET, `CDCU_DEBUG_MODE};
	logic mclk = 1'b0;
	logic rst_n, clk_en, cp_req, cp_priv, data_abort_in, cp_done, cp_undef, ext_wr;
	logic [3:0] cp_num, cp_crn, cp_crm;
	logic [2:0] cp_op1, cp_op2;
	logic [31:0] cp_wdata, ext_rdata, cp_rdata, dout;
	logic jtag_tck, jtag_tdi, jtag_sel, jtag_trst_n, jtag_tdo, jtag_tdo_oe;
	logic evt_ibrk, evt_dbrk, evt_bkpt, evt_ext, evt_tbfull, dbg_take;
	logic bkpt_loop, trace_run, halt_mode;
	logic [6:0] vec_hit;
	logic [4:0] dbg_mode;
	cdcu_op_t cp_op;
	cdcu_rsel_t ext_sel;
	cdcu_vec_t dbg_vec;
	int n_errors = 0;
	int compares = 0;
	int seed = 32'h28DB;
	typedef struct {logic u; logic w; logic c; logic [31:0] d; cdcu_rsel_t s;} cdcu_note_t;
	cdcu_note_t cpq[$];
	logic [6:0] evq[$];
	logic [4:0] t_ev[9] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1F, 5'h1F, 5'h1D, 5'h15};
	logic [6:0] t_hit[9] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h40, 7'h00, 7'h00};
	logic [2:0] t_code[9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h2, 3'h5, 3'h4, 3'h6};
	logic [3:0] sys_crm[5] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4};

	always #2.5 mclk = ~mclk;

	cdcu_top #(.ABORT_MODE_CODE(ABT)) i_cdcu_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
		.cp_req(cp_req), .cp_num(cp_num), .cp_op(cp_op), .cp_op1(cp_op1), .cp_crn(cp_crn),
		.cp_crm(cp_crm), .cp_op2(cp_op2), .cp_priv(cp_priv), .cp_wdata(cp_wdata),
		.ext_rdata(ext_rdata), .cp_done(cp_done), .cp_undef(cp_undef), .cp_rdata(cp_rdata),
		.ext_sel(ext_sel), .ext_wr(ext_wr), .jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi),
		.jtag_sel(jtag_sel), .jtag_trst_n(jtag_trst_n), .jtag_tdo(jtag_tdo),
		.jtag_tdo_oe(jtag_tdo_oe), .evt_ibrk(evt_ibrk), .evt_dbrk(evt_dbrk),
		.evt_bkpt(evt_bkpt), .evt_ext(evt_ext), .evt_tbfull(evt_tbfull), .vec_hit(vec_hit),
		.data_abort_in(data_abort_in), .dbg_take(dbg_take), .dbg_vec(dbg_vec),
		.dbg_mode(dbg_mode), .bkpt_loop(bkpt_loop), .trace_run(trace_run),
		.halt_mode(halt_mode));
	cdcu_jtag_host i_cdcu_jtag_host (.jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi),
		.jtag_sel(jtag_sel), .jtag_trst_n(jtag_trst_n), .jtag_tdo(jtag_tdo),
		.jtag_tdo_oe(jtag_tdo_oe));

	// one request per call; back-to-back calls keep the strobe up
	task automatic cp_go(input logic [3:0] num, input cdcu_op_t op, input logic [3:0] crn,
		input logic [3:0] crm, input logic [31:0] wd, input logic priv);
		@(negedge mclk);
		cp_req = 1'b1;
		cp_num = num;
		cp_op = op;
		cp_crn = crn;
		cp_crm = (num == `CDCU_CP_DBG) ? 4'($random(seed)) : crm;
		cp_op1 = (num == `CDCU_CP_DBG) ? 3'($random(seed)) : 3'h0;
		cp_op2 = (num == `CDCU_CP_DBG) ? 3'($random(seed)) : 3'h0;
		cp_wdata = wd;
		cp_priv = priv;
	endtask : cp_go
	task automatic cp_idle();
		@(negedge mclk);
		cp_req = 1'b0;
	endtask : cp_idle
	task automatic note(input logic u, w, c, input logic [31:0] d, input cdcu_rsel_t s);
		cpq.push_back('{u, w, c, d, s});
	endtask : note
	task automatic rd_cs(input logic [31:0] e);
		cp_go(`CDCU_CP_DBG, CPOP_READ, `CDCU_CRN_CTLSTAT, 4'h0, 32'h0, 1'b1);
		note(1'b0, 1'b0, 1'b1, e, RS_CTLSTAT);
	endtask : rd_cs
	task automatic wr_cs(input logic [31:0] d);
		cp_go(`CDCU_CP_DBG, CPOP_WRITE, `CDCU_CRN_CTLSTAT, 4'h0, d, 1'b1);
		note(1'b0, 1'b0, 1'b0, 32'h0, RS_CTLSTAT);
	endtask : wr_cs
	// event levels held for exactly one cycle
	task automatic fire(input logic [4:0] ev, input logic [6:0] hit, input logic abt,
		input logic take, input logic [6:0] nt);
		@(negedge mclk);
		{evt_tbfull, evt_ext, evt_bkpt, evt_dbrk, evt_ibrk} = ev;
		vec_hit = hit;
		data_abort_in = abt;
		if (take)
			evq.push_back(nt);
		@(negedge mclk);
		{evt_tbfull, evt_ext, evt_bkpt, evt_dbrk, evt_ibrk} = 5'h0;
		vec_hit = 7'h0;
		data_abort_in = 1'b0;
	endtask : fire
	task automatic rst_pulse();
		@(negedge mclk);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
	endtask : rst_pulse
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	// monitor: every answer or entry takes the oldest note
	always @(negedge mclk) begin
		cdcu_note_t n;
		logic [6:0] ev;
		if (cp_done === 1'b1 || cp_undef === 1'b1) begin
			if (cpq.size() == 0) `CHK("answer", 1'b0, 1'b1)
			else begin
				n = cpq.pop_front();
				`CHK("cp_undef", n.u, cp_undef)
				`CHK("cp_done", ~n.u, cp_done)
				`CHK("ext_wr", n.w, ext_wr)
				`CHK("ext_sel", n.s, ext_sel)
				if (n.c) `CHK("cp_rdata", n.d, cp_rdata)
			end
		end
		if (dbg_take === 1'b1) begin
			if (evq.size() == 0) `CHK("entry", 1'b0, 1'b1)
			else begin
				ev = evq.pop_front();
				`CHK("dbg_vec", ev[6:5], dbg_vec)
				`CHK("dbg_mode", ev[4:0], dbg_mode)
			end
		end
	end

	// watchdog, far beyond the expected run length
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_n, cp_req, cp_priv, data_abort_in, cp_num, cp_crn, cp_crm} = '0;
		{cp_op1, cp_op2, cp_wdata, vec_hit} = '0;
		{evt_tbfull, evt_ext, evt_bkpt, evt_dbrk, evt_ibrk} = 5'h0;
		clk_en = 1'b1;
		cp_op = CPOP_READ;
		ext_rdata = $random(seed);
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		i_cdcu_jtag_host.test_reset();
		rd_cs(32'h0);
		cp_idle();
		`CHK("bkpt_loop", 1'b1, bkpt_loop)
		$display("test reset_values finished");
		// each path writes only its own bits
		wr_cs(32'hFFFFFFFF);
		rd_cs(32'h8000003F);
		cp_idle();
		i_cdcu_jtag_host.scan(32'hFFFFFFFF, dout);
		`CHK("scan out", 32'h8000003F, dout)
		rd_cs(32'hC0DF003F);
		cp_idle();
		`CHK("halt_mode", 1'b1, halt_mode)
		`CHK("trace_run", 1'b1, trace_run)
		$display("test access_paths finished");
		// processor reset versus test reset
		rst_pulse();
		rd_cs(32'h40DF0000);
		wr_cs(32'h8000003F);
		rd_cs(32'hC0DF003F);
		cp_idle();
		i_cdcu_jtag_host.test_reset();
		rd_cs(32'h8000003F);
		cp_idle();
		$display("test resets finished");
		// decode of both register banks, back to back
		for (int c = 8; c < 15; c++) begin
			cp_go(`CDCU_CP_DBG, c[0] ? CPOP_STORE : CPOP_READ, 4'(c), 4'h0, 32'h0, 1'b1);
			note(1'b0, 1'b0, 1'b1, c == 10 ? 32'h8000003F : ext_rdata, cdcu_rsel_t'(c - 2));
		end
		for (int c = 8; c < 15; c++) begin
			if (c != 10) begin
				cp_go(`CDCU_CP_DBG, c[0] ? CPOP_LOAD : CPOP_WRITE, 4'(c), 4'h0, ext_rdata, 1'b1);
				note(1'b0, 1'b1, 1'b0, 32'h0, cdcu_rsel_t'(c - 2));
			end
		end
		for (int k = 0; k < 5; k++) begin
			cp_go(`CDCU_CP_SYS, CPOP_READ, `CDCU_SYS_CRN, sys_crm[k], 32'h0, 1'b1);
			note(1'b0, 1'b0, 1'b1, ext_rdata, cdcu_rsel_t'(k + 1));
			cp_go(`CDCU_CP_SYS, CPOP_WRITE, `CDCU_SYS_CRN, sys_crm[k], ext_rdata, 1'b1);
			note(1'b0, 1'b1, 1'b0, 32'h0, cdcu_rsel_t'(k + 1));
		end
		$display("test decode finished");
		// refused requests leave the register alone
		cp_go(`CDCU_CP_DBG, CPOP_WRITE, `CDCU_CRN_CTLSTAT, 4'h0, 32'h0, 1'b0);
		note(1'b1, 1'b0, 1'b1, 32'h0, RS_NONE);
		cp_go(`CDCU_CP_SYS, CPOP_READ, `CDCU_SYS_CRN, 4'h8, 32'h0, 1'b0);
		note(1'b1, 1'b0, 1'b1, 32'h0, RS_NONE);
		cp_go(`CDCU_CP_DBG, CPOP_DATA, `CDCU_CRN_CTLSTAT, 4'h0, 32'h0, 1'b1);
		note(1'b1, 1'b0, 1'b1, 32'h0, RS_NONE);
		cp_go(`CDCU_CP_SYS, CPOP_LOAD, `CDCU_SYS_CRN, 4'h8, 32'h0, 1'b1);
		note(1'b1, 1'b0, 1'b1, 32'h0, RS_NONE);
		cp_go(4'h5, CPOP_WRITE, `CDCU_CRN_CTLSTAT, 4'h0, 32'h0, 1'b1);
		rd_cs(32'h8000003F);
		cp_idle();
		// a request made while the clock enable is low must leave no trace
		@(negedge mclk);
		clk_en = 1'b0;
		cp_go(`CDCU_CP_DBG, CPOP_WRITE, `CDCU_CRN_CTLSTAT, 4'h0, 32'h0, 1'b1);
		cp_idle();
		clk_en = 1'b1;
		rd_cs(32'h8000003F);
		cp_idle();
		$display("test refusals finished");
		// monitor mode entries
		fire(5'h01, 7'h0, 1'b0, 1'b1, {VEC_PABT, ABT});
		rd_cs(32'h80000026);
		cp_idle();
		fire(5'h02, 7'h0, 1'b0, 1'b1, {VEC_DABT, ABT});
		rd_cs(32'h8000002A);
		cp_idle();
		i_cdcu_jtag_host.scan(32'h40DF0000, dout);
		`CHK("scan out", 32'h8000002A, dout)
		// halt mode: every cause alone, then together
		for (int k = 0; k < 9; k++) begin
			fire(t_ev[k], t_hit[k], 1'b0, 1'b1, HLT);
			rd_cs({16'hC0DF, 10'h0, 1'b1, t_code[k], 2'b10});
			cp_idle();
		end
		for (int b = 0; b < 7; b++) begin
			fire(5'h0, 7'(1 << b), 1'b0, 1'b1, HLT);
			rd_cs(32'hC0DF0036);
			cp_idle();
		end
		wr_cs(32'h80000000);
		cp_idle();
		fire(5'h0, 7'h0, 1'b1, 1'b0, HLT);
		rd_cs(32'hC0DF0020);
		cp_idle();
		$display("test entries finished");
		// global enable off: only the reset trap survives
		wr_cs(32'h0);
		cp_idle();
		`CHK("bkpt_loop", 1'b1, bkpt_loop)
		`CHK("trace_run", 1'b0, trace_run)
		fire(5'h1F, 7'h7E, 1'b0, 1'b0, HLT);
		rd_cs(32'h40DF0000);
		cp_idle();
		fire(5'h0, 7'h01, 1'b0, 1'b1, HLT);
		rd_cs(32'h40DF0014);
		cp_idle();
		repeat (3) @(negedge mclk);
		`CHK("left notes", 0, cpq.size() + evq.size())
		$display("test global_enable finished");
		give_verdict();
	end
endmodule : core_debug_control_unit_tb_top
`default_nettype wire
